// ---- rtl/converter_pkg.sv ----
// Shared constants and types for the converter conversion control.
// Assumes a 100 MHz system clock and a 32-bit classic Wishbone register port.
package converter_pkg;

  // Register byte offsets, one aligned word each.
  localparam logic [4:0] ADDR_CTRL_A      = 5'h00;
  localparam logic [4:0] ADDR_CTRL_B      = 5'h04;
  localparam logic [4:0] ADDR_INPUT_SEL   = 5'h08;
  localparam logic [4:0] ADDR_RESULT_LOW  = 5'h0C;
  localparam logic [4:0] ADDR_RESULT_HIGH = 5'h10;
  localparam logic [4:0] ADDR_POWER       = 5'h14;

  // converter_control_a fields.
  localparam int BIT_ENABLE = 7;
  localparam int BIT_START  = 6;
  localparam int BIT_AUTO   = 5;
  localparam int BIT_FLAG   = 4;
  localparam int BIT_IE     = 3;
  localparam int PS_LSB     = 0;
  // converter_control_b, input_select_register and power register fields.
  localparam int TS_LSB     = 0;
  localparam int REFERENCE_SELECT_FIELD_LSB   = 6;
  localparam int BIT_LEFT   = 5;
  localparam int MUX_LSB    = 0;
  localparam int BIT_PRR    = 0;

  // Reset values.
  localparam logic [7:0] RESET_BYTE  = 8'h00;
  localparam logic       RESET_POWER = 1'b0;

  // Conversion timing in converter clock cycles, counted in half cycles.
  localparam int NORMAL_CYCLES       = 13;
  localparam int FIRST_CYCLES        = 25;
  localparam int NORMAL_DONE_HALVES  = 2 * NORMAL_CYCLES;
  localparam int FIRST_DONE_HALVES   = 2 * FIRST_CYCLES;
  localparam int AUTO_DONE_HALVES    = 27;  // 13.5 cycles.
  localparam int NORMAL_SAMPLE_HALVES = 3;  // 1.5 cycles.
  localparam int FIRST_SAMPLE_HALVES = 27;  // 13.5 cycles.
  localparam int AUTO_SAMPLE_HALVES  = 4;   // 2 cycles.
  localparam int TRIG_SYNC_CYCLES    = 3;

  localparam logic [2:0] TS_FREE_RUN = 3'h0;

  typedef enum logic [1:0] {
    KIND_NORMAL = 2'b00,
    KIND_FIRST  = 2'b01,
    KIND_AUTO   = 2'b10
  } conv_kind_t;

  // Request carried to the analog sampling and comparison core.
  typedef struct packed {
    logic       busy;
    logic       sample;
    logic       first;
    logic [1:0] reference;
    logic [3:0] channel;
  } core_req_t;

  // Division ratio selected by prescaler_select_field.
  function automatic logic [7:0] prescale_ratio(input logic [2:0] sel);
    prescale_ratio = (sel == 3'h0) ? 8'h02 : 8'(8'h01 << sel);
  endfunction : prescale_ratio

endpackage : converter_pkg

// ---- rtl/converter_prescaler.sv ----
// Converter clock prescaler producing rising and falling tick pulses.
// Assumes run and restart come from logic on the same clock.
`timescale 1ns/10ps
`default_nettype none
module converter_prescaler
  import converter_pkg::*;
(
  // Clock and reset.
  input  wire logic       clk,
  input  wire logic       rst_n,
  // Control.
  input  wire logic       run,
  input  wire logic       restart,
  input  wire logic [2:0] sel,
  // Ticks.
  output logic            rise_tick,
  output logic            fall_tick
);

  logic [7:0] count;
  logic [7:0] next_count;
  logic [7:0] ratio;

  always_comb begin
    ratio = prescale_ratio(sel);
    rise_tick = run && !restart && (count == ratio - 8'h01);
    fall_tick = run && !restart && (count == (ratio >> 1) - 8'h01);
    if (!run || restart || rise_tick) begin
      next_count = 8'h00;
    end else begin
      next_count = count + 8'h01;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count <= 8'h00;
    end else begin
      count <= next_count;
    end
  end

  property p_held_reset;
    @(posedge clk) disable iff (!rst_n) !run |=> count == 8'h00;
  endproperty
  a_held_reset: assert property (p_held_reset) else $error("prescaler not held in reset");

endmodule : converter_prescaler
`default_nettype wire

// ---- rtl/converter_result.sv ----
// Result store with low-then-high read lock and alignment on readout.
// Assumes read strobes are single-cycle pulses from the bus slave.
`timescale 1ns/10ps
`default_nettype none
module converter_result
  import converter_pkg::*;
(
  // Clock and reset.
  input  wire logic       clk,
  input  wire logic       rst_n,
  // Conversion side.
  input  wire logic       store,
  input  wire logic [9:0] data,
  // Software side.
  input  wire logic       left,
  input  wire logic       read_low,
  input  wire logic       read_high,
  output logic [7:0]      low_byte,
  output logic [7:0]      high_byte
);

  logic [9:0] value;
  logic [9:0] next_value;
  logic       locked;
  logic       next_locked;

  always_comb begin
    next_value = value;
    if (store && !locked) begin
      next_value = data;
    end
    next_locked = locked;
    if (read_low) begin
      next_locked = 1'b1;
    end else if (read_high) begin
      next_locked = 1'b0;
    end
    if (left) begin
      high_byte = value[9:2];
      low_byte  = {value[1:0], 6'h00};
    end else begin
      high_byte = {6'h00, value[9:8]};
      low_byte  = value[7:0];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      value  <= 10'h000;
      locked <= 1'b0;
    end else begin
      value  <= next_value;
      locked <= next_locked;
    end
  end

  property p_locked_keeps;
    @(posedge clk) disable iff (!rst_n) (locked && !read_high) |=> $stable(value);
  endproperty
  a_locked_keeps: assert property (p_locked_keeps) else $error("result changed while locked");

endmodule : converter_result
`default_nettype wire

// ---- rtl/converter_control.sv ----
// Conversion control for a 10-bit successive-approximation converter.
// Assumes software on classic Wishbone and an analog core on the same clock.
//
// What this block does
// - Selections ignored and idle while enable clear.
// - Ten-bit result right aligned, or left aligned.
// - Low byte read locks result until high read.
// - Complete flag still sets while result locked.
// - Start bit high through conversion, then cleared.
// - Channel change waits for current conversion end.
// - Auto-trigger launches from selected trigger source.
// - Trigger rising edge resets prescaler, starts conversion.
// - Held level or edges during conversion ignored.
// - Complete-flag trigger runs back to back.
// - Start bit works under auto-trigger, reads busy.
// - Prescaler divides clock, held reset while disabled.
// - Single conversion begins next converter rising edge.
// - Conversion takes 13 cycles, first 25.
// - Sample at 1.5 cycles, first at 13.5.
// - Completion writes result, sets flag, clears start.
// - Auto sample at 2 cycles, 13.5 total.
// - Free running restarts at once, start stays.
// - Trigger select codes 1 to 7 map seven sources.
// - Select inert without auto; free run no edge.
// - Selections held frozen, reopen in last cycle.
`timescale 1ns/10ps
`default_nettype none
module converter_control
  import converter_pkg::*;
(
  // Clock and reset.
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Wishbone slave.
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [4:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic             wb_ack_o,
  output logic [31:0]      wb_dat_o,
  // Trigger sources, bit n for trigger_select_field code n, n from 1 to 7; bit 0 unused.
  input  wire logic [7:0]  trigger_sources,
  // Interrupt vector taken and interrupt request.
  input  wire logic        irq_ack,
  output logic             irq,
  // Analog core.
  input  wire logic [9:0]  core_result,
  output core_req_t        core_req
);

  ////////////////////////////////////////////////////////////////////////////
  // Register state.

  logic       converter_enable_bit, next_enable;
  logic       auto_trigger_enable, next_auto;
  logic       interrupt_enable, next_ie;
  logic       conversion_complete_flag, next_flag;
  logic [2:0] prescaler_select_field, next_ps;
  logic [2:0] trigger_select_field, next_ts;
  logic [1:0] reference_select_field, next_reference_select_field;
  logic       left_adjust_bit, next_left;
  logic [3:0] channel_select_field, next_mux;
  logic       converter_power_reduce, next_prr;
  logic       next_ack;
  logic [31:0] next_dat;
  logic       next_irq;

  logic       access;
  logic       wr;
  logic       read_low;
  logic       read_high;
  logic [7:0] low_byte;
  logic [7:0] high_byte;

  ////////////////////////////////////////////////////////////////////////////
  // Conversion state.

  logic       active;
  logic       busy, next_busy;
  logic       pending, next_pending;
  logic       first, next_first;
  conv_kind_t kind, next_kind;
  logic [5:0] halves, next_halves;
  logic [5:0] step;
  logic       tick;
  logic       rise_tick;
  logic       fall_tick;
  logic       done;
  logic       sample_now;
  logic       free_run;
  logic       start_bit;
  logic       start_single;
  logic       start_trig;
  logic       hold_open;
  logic [1:0] hold_reference_select_field, next_hold_reference_select_field;
  logic [3:0] hold_mux, next_hold_mux;
  core_req_t  next_req;

  // Trigger path: edge detect, then a fixed synchronisation delay.
  logic                        trig_level;
  logic                        trig_prev;
  logic [TRIG_SYNC_CYCLES-1:0] trig_pipe, next_trig_pipe;

  function automatic logic [5:0] done_halves(input conv_kind_t k);
    case (k)
      KIND_FIRST: done_halves = 6'(FIRST_DONE_HALVES);
      KIND_AUTO:  done_halves = 6'(AUTO_DONE_HALVES);
      default:    done_halves = 6'(NORMAL_DONE_HALVES);
    endcase
  endfunction : done_halves

  function automatic logic [5:0] sample_halves(input conv_kind_t k);
    case (k)
      KIND_FIRST: sample_halves = 6'(FIRST_SAMPLE_HALVES);
      KIND_AUTO:  sample_halves = 6'(AUTO_SAMPLE_HALVES);
      default:    sample_halves = 6'(NORMAL_SAMPLE_HALVES);
    endcase
  endfunction : sample_halves

  ////////////////////////////////////////////////////////////////////////////
  // Submodules.

  converter_prescaler u_prescaler (
    .clk       (clk),
    .rst_n     (rst_n),
    .run       (active),
    .restart   (start_trig),
    .sel       (prescaler_select_field),
    .rise_tick (rise_tick),
    .fall_tick (fall_tick)
  );

  converter_result u_result (
    .clk       (clk),
    .rst_n     (rst_n),
    .store     (done),
    .data      (core_result),
    .left      (left_adjust_bit),
    .read_low  (read_low),
    .read_high (read_high),
    .low_byte  (low_byte),
    .high_byte (high_byte)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Conversion sequencing.

  always_comb begin
    active     = converter_enable_bit && !converter_power_reduce;
    free_run   = auto_trigger_enable && (trigger_select_field == TS_FREE_RUN);
    // Code zero picks no source, so moving to free run cannot make an edge.
    trig_level = auto_trigger_enable && (trigger_select_field != TS_FREE_RUN)
                 && trigger_sources[trigger_select_field];
    next_trig_pipe = {trig_pipe[TRIG_SYNC_CYCLES-2:0], trig_level && !trig_prev};
    start_trig = active && !busy && trig_pipe[TRIG_SYNC_CYCLES-1];
    start_single = active && !busy && pending && rise_tick && !start_trig;
    tick       = rise_tick || fall_tick;
    step       = halves + 6'h01;
    done       = busy && tick && (step == done_halves(kind));
    sample_now = busy && tick && (step == sample_halves(kind));
    start_bit  = busy || pending;
    hold_open  = !busy || (halves >= done_halves(kind) - 6'h02);

    next_busy    = busy;
    next_pending = pending;
    next_first   = first;
    next_kind    = kind;
    next_halves  = tick ? step : halves;
    if (!active) begin
      next_busy    = 1'b0;
      next_pending = 1'b0;
      next_halves  = 6'h00;
    end else if (start_trig || start_single) begin
      next_busy    = 1'b1;
      next_pending = 1'b0;
      next_halves  = 6'h00;
      next_kind    = first ? KIND_FIRST : (start_trig ? KIND_AUTO : KIND_NORMAL);
    end else if (done) begin
      next_first   = 1'b0;
      next_halves  = 6'h00;
      next_kind    = KIND_NORMAL;
      next_busy    = free_run;
    end
    if (wr && (wb_adr_i == ADDR_CTRL_A) && wb_sel_i[0]) begin
      // A start is only taken while running and staying on; otherwise it would linger past disable.
      if (wb_dat_i[BIT_START] && wb_dat_i[BIT_ENABLE] && active && !busy) begin
        next_pending = 1'b1;
      end
      if (wb_dat_i[BIT_ENABLE] && !converter_enable_bit) begin
        next_first = 1'b1;
      end
    end

    next_hold_reference_select_field = hold_reference_select_field;
    next_hold_mux  = hold_mux;
    if (active && hold_open) begin
      next_hold_reference_select_field = reference_select_field;
      next_hold_mux  = channel_select_field;
    end

    next_req.busy      = next_busy;
    next_req.sample    = sample_now;
    next_req.first     = next_busy && (next_kind == KIND_FIRST);
    next_req.reference = next_hold_reference_select_field;
    next_req.channel   = next_hold_mux;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register bus.

  always_comb begin
    access    = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wr        = access && wb_we_i;
    read_low  = access && !wb_we_i && (wb_adr_i == ADDR_RESULT_LOW);
    read_high = access && !wb_we_i && (wb_adr_i == ADDR_RESULT_HIGH);
    next_ack  = access;

    next_enable = converter_enable_bit;
    next_auto   = auto_trigger_enable;
    next_ie     = interrupt_enable;
    next_ps     = prescaler_select_field;
    next_ts     = trigger_select_field;
    next_reference_select_field   = reference_select_field;
    next_left   = left_adjust_bit;
    next_mux    = channel_select_field;
    next_prr    = converter_power_reduce;
    next_flag   = conversion_complete_flag;
    if (irq_ack) begin
      next_flag = 1'b0;
    end
    if (wr && wb_sel_i[0]) begin
      if (wb_adr_i == ADDR_CTRL_A) begin
        next_enable = wb_dat_i[BIT_ENABLE];
        next_auto   = wb_dat_i[BIT_AUTO];
        next_ie     = wb_dat_i[BIT_IE];
        next_ps     = wb_dat_i[PS_LSB +: 3];
        if (wb_dat_i[BIT_FLAG]) begin
          next_flag = 1'b0;
        end
      end else if (wb_adr_i == ADDR_CTRL_B) begin
        next_ts = wb_dat_i[TS_LSB +: 3];
      end else if (wb_adr_i == ADDR_INPUT_SEL) begin
        next_reference_select_field = wb_dat_i[REFERENCE_SELECT_FIELD_LSB +: 2];
        next_left = wb_dat_i[BIT_LEFT];
        next_mux  = wb_dat_i[MUX_LSB +: 4];
      end else if (wb_adr_i == ADDR_POWER) begin
        next_prr = wb_dat_i[BIT_PRR];
      end
    end
    // Completion beats a clear in the same cycle, even when the result is dropped.
    if (done) begin
      next_flag = 1'b1;
    end
    next_irq = next_flag && next_ie;

    next_dat = 32'h0000_0000;
    if (access && !wb_we_i) begin
      if (wb_adr_i == ADDR_CTRL_A) begin
        next_dat[7:0] = {converter_enable_bit, start_bit, auto_trigger_enable,
                         conversion_complete_flag, interrupt_enable, prescaler_select_field};
      end else if (wb_adr_i == ADDR_CTRL_B) begin
        next_dat[2:0] = trigger_select_field;
      end else if (wb_adr_i == ADDR_INPUT_SEL) begin
        next_dat[7:0] = {reference_select_field, left_adjust_bit, 1'b0, channel_select_field};
      end else if (wb_adr_i == ADDR_RESULT_LOW) begin
        next_dat[7:0] = low_byte;
      end else if (wb_adr_i == ADDR_RESULT_HIGH) begin
        next_dat[7:0] = high_byte;
      end else if (wb_adr_i == ADDR_POWER) begin
        next_dat[BIT_PRR] = converter_power_reduce;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers.

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      converter_enable_bit     <= 1'b0;
      auto_trigger_enable      <= 1'b0;
      interrupt_enable         <= 1'b0;
      conversion_complete_flag <= 1'b0;
      prescaler_select_field   <= RESET_BYTE[2:0];
      trigger_select_field     <= RESET_BYTE[2:0];
      reference_select_field   <= RESET_BYTE[1:0];
      left_adjust_bit          <= 1'b0;
      channel_select_field     <= RESET_BYTE[3:0];
      converter_power_reduce   <= RESET_POWER;
      wb_ack_o                 <= 1'b0;
      wb_dat_o                 <= 32'h0000_0000;
      irq                      <= 1'b0;
      busy                     <= 1'b0;
      pending                  <= 1'b0;
      first                    <= 1'b0;
      kind                     <= KIND_NORMAL;
      halves                   <= 6'h00;
      hold_reference_select_field                <= 2'h0;
      hold_mux                 <= 4'h0;
      trig_prev                <= 1'b0;
      trig_pipe                <= '0;
      core_req                 <= '0;
    end else begin
      converter_enable_bit     <= next_enable;
      auto_trigger_enable      <= next_auto;
      interrupt_enable         <= next_ie;
      conversion_complete_flag <= next_flag;
      prescaler_select_field   <= next_ps;
      trigger_select_field     <= next_ts;
      reference_select_field   <= next_reference_select_field;
      left_adjust_bit          <= next_left;
      channel_select_field     <= next_mux;
      converter_power_reduce   <= next_prr;
      wb_ack_o                 <= next_ack;
      wb_dat_o                 <= next_dat;
      irq                      <= next_irq;
      busy                     <= next_busy;
      pending                  <= next_pending;
      first                    <= next_first;
      kind                     <= next_kind;
      halves                   <= next_halves;
      hold_reference_select_field                <= next_hold_reference_select_field;
      hold_mux                 <= next_hold_mux;
      trig_prev                <= trig_level;
      trig_pipe                <= next_trig_pipe;
      core_req                 <= next_req;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  property p_flag_sets;
    @(posedge clk) disable iff (!rst_n) done |=> conversion_complete_flag;
  endproperty
  a_flag_sets: assert property (p_flag_sets) else $error("flag missed a completion");

  property p_idle_disabled;
    @(posedge clk) disable iff (!rst_n) !active |=> !busy && !pending;
  endproperty
  a_idle_disabled: assert property (p_idle_disabled) else $error("activity while disabled");

  property p_single_clears;
    @(posedge clk) disable iff (!rst_n) (done && !free_run) |=> !busy && !core_req.busy;
  endproperty
  a_single_clears: assert property (p_single_clears) else $error("start not cleared");

  property p_free_restart;
    @(posedge clk) disable iff (!rst_n) (done && free_run && active) |=> busy && halves == 6'h00;
  endproperty
  a_free_restart: assert property (p_free_restart) else $error("free run did not restart");

  property p_done_length;
    @(posedge clk) disable iff (!rst_n) done |-> step == done_halves(kind) && busy;
  endproperty
  a_done_length: assert property (p_done_length) else $error("wrong conversion length");

  property p_sample_point;
    @(posedge clk) disable iff (!rst_n) sample_now |=> core_req.sample && halves == sample_halves(kind);
  endproperty
  a_sample_point: assert property (p_sample_point) else $error("sample at wrong point");

  property p_hold_frozen;
    @(posedge clk) disable iff (!rst_n) (busy && !hold_open && active) |=> $stable(hold_mux);
  endproperty
  a_hold_frozen: assert property (p_hold_frozen) else $error("channel changed mid conversion");

  property p_busy_reads_start;
    @(posedge clk) disable iff (!rst_n) busy |-> start_bit;
  endproperty
  a_busy_reads_start: assert property (p_busy_reads_start) else $error("start bit low while busy");

  property p_edge_ignored;
    @(posedge clk) disable iff (!rst_n) (busy && trig_pipe[TRIG_SYNC_CYCLES-1] && !done) |=> $stable(kind);
  endproperty
  a_edge_ignored: assert property (p_edge_ignored) else $error("trigger accepted mid conversion");

endmodule : converter_control
`default_nettype wire

// ---- sim/analog_core_model.sv ----
// Behavioural model of the analog sampling and comparison core.
// Assumes the control drives core_req on clk and reads core_result while busy.
`timescale 1ns/10ps
`default_nettype none
module analog_core_model
  import converter_pkg::*;
(
  // Clock and reset.
  input  wire logic      clk,
  input  wire logic      rst_n,
  // Request and analog input level.
  input  wire core_req_t core_req,
  input  wire logic [9:0] level,
  // Result.
  output logic [9:0]     core_result
);
  logic [9:0] held;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      held <= 10'h000;
    end else if (core_req.sample) begin
      held <= level ^ {6'h00, core_req.channel};
    end
  end
  // Outside a conversion the lines show the inverse, so stale data never passes as a result.
  assign core_result = core_req.busy ? held : ~held;
endmodule : analog_core_model
`default_nettype wire

// ---- sim/tb_sar_adc_conversion_control.sv ----
// Self-checking bench for the converter control.
// Assumes the analog core model and a 100 MHz clock.
`timescale 1ns/10ps
`default_nettype none
module tb_sar_adc_conversion_control
  import converter_pkg::*;
();
  logic        clk, rst_n, cyc, stb, we, ack, irq_ack, irq;
  logic [4:0]  adr;
  logic [3:0]  sel;
  logic [31:0] wdat, rdat, q;
  logic [7:0]  trig;
  logic [9:0]  level, res, v;
  logic [3:0]  ch;
  logic [2:0]  s;
  core_req_t   req;
  int          fails, comparisons, r, k, n1, n2, c, bc, b0;
  converter_control DUT (.clk(clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_ack_o(ack), .wb_dat_o(rdat),
    .trigger_sources(trig), .irq_ack(irq_ack), .irq(irq), .core_result(res), .core_req(req));
  analog_core_model core (.clk(clk), .rst_n(rst_n), .core_req(req), .level(level), .core_result(res));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) bc <= bc + int'(req.busy === 1'b1);
  //////////////////////////////////////////////////////////////////////////////
  task automatic summarize;
    $display("fails=%0d comparisons=%0d", fails, comparisons);
    if (fails == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : summarize
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wb(input logic w, input logic [4:0] a, input logic [7:0] d);
    int i;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    sel <= 4'hF;
    adr <= a;
    wdat <= {24'h000000, d};
    for (i = 0; i < 20 && ack !== 1'b1; i++) @(posedge clk);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (i == 20) begin
      fails++;
      summarize();
    end
  endtask : wb
  // Bounded wait on busy or on the sample pulse; a hang ends the run.
  task automatic wait_for(input bit smp, input logic val, output int n);
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while ((smp ? req.sample : req.busy) !== val && n < 9000);
    if (n >= 9000) begin
      fails++;
      summarize();
    end
  endtask : wait_for
  task automatic conv(input int dh, input int sh);
    wait_for(0, 1'b1, k);
    wait_for(1, 1'b1, n1);
    wait_for(0, 1'b0, n2);
    chk(n1 + n2, dh * r / 2);
    chk(n2, (dh - sh) * r / 2);
  endtask : conv
  task automatic rd_res(input logic left);
    v = level ^ {6'h00, ch};
    wb(0, ADDR_RESULT_LOW, 8'h00);
    chk(q, 32'(left ? {v[1:0], 6'h00} : v[7:0]));
    wb(0, ADDR_RESULT_HIGH, 8'h00);
    chk(q, 32'(left ? v[9:2] : {6'h00, v[9:8]}));
  endtask : rd_res
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    {cyc, stb, we, irq_ack, adr, sel, wdat, trig, fails, comparisons} = '0;
    rst_n = 1'b0;
    k = $urandom(32'hD7DD);
    level = 10'($urandom);
    ch = 4'($urandom);
    s = 3'($urandom_range(2, 0));
    r = (s == 3'h0) ? 2 : (1 << s);
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    for (c = 0; c < 7; c++) begin
      wb(0, 5'(c * 4), 8'h00);
      chk(q, 32'h0);
    end
    b0 = bc;
    wb(1, ADDR_CTRL_A, 8'h48);
    repeat (80) @(posedge clk);
    chk(bc, b0);
    wb(1, ADDR_POWER, 8'h01);
    wb(1, ADDR_CTRL_A, 8'hC8);
    repeat (80) @(posedge clk);
    chk(bc, b0);
    wb(1, ADDR_POWER, 8'h00);
    wb(1, ADDR_INPUT_SEL, {4'h4, ch});
    wb(1, ADDR_CTRL_A, 8'h80 | s);
    wb(1, ADDR_CTRL_A, 8'hC8 | s);
    conv(50, 27);
    chk(k <= r + 2, 1);
    wb(0, ADDR_CTRL_A, 8'h00);
    chk(q, 32'(8'h98 | s));
    chk(irq, 1'b1);
    rd_res(0);
    wb(1, ADDR_INPUT_SEL, {4'h6, ch});
    rd_res(1);
    wb(1, ADDR_CTRL_A, 8'h88 | s);
    wb(0, ADDR_CTRL_A, 8'h00);
    chk(q, 32'(8'h98 | s));
    @(posedge clk) irq_ack <= 1'b1;
    @(posedge clk) irq_ack <= 1'b0;
    wb(0, ADDR_CTRL_A, 8'h00);
    chk(q, 32'(8'h88 | s));
    // Lock the result, then convert while it is locked and change the channel mid conversion.
    wb(1, ADDR_INPUT_SEL, {4'h4, ch});
    v = level ^ {6'h00, ch};
    wb(0, ADDR_RESULT_LOW, 8'h00);
    level = 10'($urandom);
    wb(1, ADDR_CTRL_A, 8'hC8 | s);
    wait_for(0, 1'b1, k);
    wait_for(1, 1'b1, k);
    wb(1, ADDR_INPUT_SEL, {4'h4, ~ch});
    wb(0, ADDR_CTRL_A, 8'h00);
    chk(q, 32'(8'hC8 | s));
    chk(req.channel, ch);
    wait_for(0, 1'b0, k);
    wb(0, ADDR_RESULT_HIGH, 8'h00);
    chk(q, 32'({6'h00, v[9:8]}));
    chk(irq, 1'b1);
    wb(1, ADDR_CTRL_A, 8'hD8 | s);
    ch = ~ch;
    conv(26, 3);
    rd_res(0);
    // Trigger codes 1 to 7; an unselected source must not start anything.
    wb(1, ADDR_CTRL_A, 8'hB0 | s);
    for (c = 1; c < 8; c++) begin
      wb(1, ADDR_CTRL_B, 8'(c));
      b0 = bc;
      trig <= 8'(1 << (c % 7 + 1));
      repeat (30) @(posedge clk);
      chk(bc, b0);
      trig <= trig | 8'(1 << c);
      conv(27, 4);
      b0 = bc;
      repeat (30 * r) @(posedge clk);
      chk(bc, b0);
      trig <= 8'h00;
    end
    // Free running: restart at each completion with the start bit kept high.
    wb(1, ADDR_CTRL_B, 8'(TS_FREE_RUN));
    wb(1, ADDR_CTRL_A, 8'hF0 | s);
    wait_for(1, 1'b1, k);
    wait_for(1, 1'b1, n1);
    chk(n1, 13 * r);
    wb(0, ADDR_CTRL_A, 8'h00);
    chk(q[6], 1'b1);
    summarize();
  end
endmodule : tb_sar_adc_conversion_control
`default_nettype wire
